// File: instr_exec_pkg.sv
// Shared constants and types for the instruction execution block
package instr_exec_pkg;

	localparam int DATA_W   = 8;
	localparam int PC_W     = 12;
	localparam int MEM_AW   = 7;
	localparam int MEM_DEPTH = 128;
	localparam int STACK_AW = 3;
	localparam int STACK_DEPTH = 8;

	// Byte addresses of the register words
	localparam logic [7:0] OFF_INSTR    = 8'h00;
	localparam logic [7:0] OFF_STATUS   = 8'h04;
	localparam logic [7:0] OFF_ACC      = 8'h08;
	localparam logic [7:0] OFF_PC       = 8'h0C;
	localparam logic [7:0] OFF_FLAGS    = 8'h10;
	localparam logic [7:0] OFF_INT      = 8'h14;
	localparam logic [7:0] OFF_MEM_PTR  = 8'h18;
	localparam logic [7:0] OFF_MEM_DATA = 8'h1C;

	// Instruction word fields
	localparam int INSTR_OP_LSB   = 0;
	localparam int INSTR_OPD_LSB  = 8;
	localparam int INSTR_ADDR_LSB = 16;

	// Flag word bit positions
	localparam int FLAG_C   = 0;
	localparam int FLAG_AC  = 1;
	localparam int FLAG_Z   = 2;
	localparam int FLAG_OV  = 3;
	localparam int FLAG_EMI = 4;

	// Status word bit positions
	localparam int STAT_BUSY    = 0;
	localparam int STAT_CYC_LSB = 1;
	localparam int STAT_SP_LSB  = 4;

	localparam logic [PC_W-1:0]   PC_RESET     = 12'h000;
	localparam logic [PC_W-1:0]   INT_VECTOR   = 12'h004;
	localparam logic [DATA_W-1:0] ACC_RESET    = 8'h00;
	localparam logic [1:0]        CYCLES_ONE   = 2'h1;
	localparam logic [1:0]        CYCLES_TWO   = 2'h2;
	localparam logic [1:0]        RESP_OKAY    = 2'h0;
	localparam logic [1:0]        RESP_SLVERR  = 2'h2;

	typedef enum logic [4:0] {
		OP_NO_OPERATION,
		OP_JUMP_UNCONDITIONAL,
		OP_MOVE_MEM_TO_ACC,
		OP_MOVE_IMM_TO_ACC,
		OP_MOVE_ACC_TO_MEM,
		OP_OR_MEM,
		OP_OR_IMM,
		OP_OR_TO_MEMORY,
		OP_SUBROUTINE_RETURN,
		OP_RETURN_WITH_VALUE,
		OP_INTERRUPT_RETURN,
		OP_ROTATE_LEFT,
		OP_ROTATE_LEFT_TO_ACC,
		OP_ROTATE_LEFT_CARRY,
		OP_ROTATE_LEFT_CARRY_TO_ACC,
		OP_ROTATE_RIGHT,
		OP_ROTATE_RIGHT_TO_ACC,
		OP_ROTATE_RIGHT_CARRY,
		OP_ROTATE_RIGHT_CARRY_TO_ACC,
		OP_SUBTRACT_WITH_BORROW,
		OP_SUBTRACT_WITH_BORROW_TO_MEMORY,
		OP_DECREMENT_SKIP_IF_ZERO,
		OP_SUBROUTINE_CALL
	} opcode_t;

	typedef enum {
		ST_IDLE,
		ST_EXEC,
		ST_DUMMY
	} exec_state_t;

endpackage : instr_exec_pkg

// File: instr_exec.sv
// Instruction execution core slice with AXI4-Lite register access
// Contract
// - Jump loads its address into the program counter; flags unchanged.
// - Jump takes two instruction cycles with one dummy cycle.
// - Move memory to accumulator copies the byte; flags unchanged.
// - Move immediate loads the literal into the accumulator; flags unchanged.
// - Move accumulator to memory writes the byte; flags unchanged.
// - No-operation changes nothing and proceeds to the next instruction.
// - OR to accumulator with memory or literal; only zero flag updates.
// - OR to memory writes result back to the byte; only zero flag.
// - Subroutine return pops stack into program counter; flags unchanged.
// - Return with value pops program counter and loads literal into accumulator.
// - Interrupt return pops program counter and sets the master enable.
// - A pending interrupt at interrupt return is serviced before resuming.
// - Rotate left moves bit 7 into bit 0; no flags.
// - Rotate right moves bit 0 into bit 7; no flags.
// - Rotate left through carry: old carry to bit 0, bit 7 to carry.
// - Rotate right through carry: old carry to bit 7, bit 0 to carry.
// - Accumulator-target rotates write accumulator and leave the memory byte.
// - Subtract with borrow: acc minus byte minus inverted carry; four flags.
// - Carry clears on negative result, sets on zero or positive.
// - Memory-target subtract with borrow writes the difference to the byte.
// - Decrement and skip subtracts one; skips next instruction on zero.
// - A skipping decrement takes two cycles with a dummy cycle.
// - Subroutine call pushes the incremented program counter onto the stack.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps

module instr_exec (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready
);

	localparam int DW = instr_exec_pkg::DATA_W;
	localparam int PW = instr_exec_pkg::PC_W;
	localparam int INSTR_OP_MSB = instr_exec_pkg::INSTR_OP_LSB + 4;

	// Bus channel holding registers
	logic                  aw_full_q;
	logic [7:0]            aw_addr_q;
	logic                  w_full_q;
	logic [31:0]           w_data_q;
	logic [3:0]            w_strb_q;
	logic                  bvalid_q;
	logic [1:0]            bresp_q;
	logic                  rvalid_q;
	logic [31:0]           rdata_q;
	logic [1:0]            rresp_q;

	// Core state
	instr_exec_pkg::exec_state_t state_q;
	instr_exec_pkg::opcode_t     op_q;
	logic [DW-1:0]         opd_q;
	logic [PW-1:0]         addr_q;
	logic [31:0]           instr_word_q;
	logic [DW-1:0]         acc_q;
	logic [PW-1:0]         pc_q;
	logic                  c_q;
	logic                  ac_q;
	logic                  z_q;
	logic                  ov_q;
	logic                  emi_q;
	logic                  pend_q;
	logic [1:0]            cycles_q;
	logic [instr_exec_pkg::MEM_AW-1:0]   mem_ptr_q;
	logic [instr_exec_pkg::STACK_AW-1:0] sp_q;
	logic [DW-1:0]         mem [instr_exec_pkg::MEM_DEPTH];
	logic [PW-1:0]         stack [instr_exec_pkg::STACK_DEPTH];

	// Execution results
	logic [DW-1:0]         acc_d;
	logic [PW-1:0]         pc_d;
	logic                  c_d;
	logic                  ac_d;
	logic                  z_d;
	logic                  ov_d;
	logic                  emi_d;
	logic                  pend_clr;
	logic                  mem_we;
	logic [DW-1:0]         mem_wd;
	logic                  push;
	logic                  pop;
	logic [PW-1:0]         push_val;
	logic                  two_cycle;

	function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (cur & ~m) | (nw & m);
	endfunction : merge

	// Bus decode
	wire        busy     = (state_q != instr_exec_pkg::ST_IDLE);
	wire        do_write = aw_full_q && w_full_q && !bvalid_q;
	wire        do_read  = arvalid && !rvalid_q;
	wire        wr_instr = do_write && (aw_addr_q == instr_exec_pkg::OFF_INSTR);
	wire        wr_acc   = do_write && (aw_addr_q == instr_exec_pkg::OFF_ACC);
	wire        wr_pc    = do_write && (aw_addr_q == instr_exec_pkg::OFF_PC);
	wire        wr_flags = do_write && (aw_addr_q == instr_exec_pkg::OFF_FLAGS);
	wire        wr_int   = do_write && (aw_addr_q == instr_exec_pkg::OFF_INT);
	wire        wr_ptr   = do_write && (aw_addr_q == instr_exec_pkg::OFF_MEM_PTR);
	wire        wr_mdata = do_write && (aw_addr_q == instr_exec_pkg::OFF_MEM_DATA);
	wire        wr_hit   = wr_instr | wr_acc | wr_pc | wr_flags | wr_int | wr_ptr | wr_mdata
		| (aw_addr_q == instr_exec_pkg::OFF_STATUS);
	// Software changes to core state are held off while an instruction runs
	wire        sw_ok    = !busy;
	wire        start    = wr_instr && sw_ok;
	wire [31:0] instr_m  = merge(instr_word_q, w_data_q, w_strb_q);

	wire [31:0] flags_word = {27'h0000000, emi_q, ov_q, z_q, ac_q, c_q};
	wire [31:0] flags_m    = merge(flags_word, w_data_q, w_strb_q);
	wire [31:0] acc_m      = merge({24'h000000, acc_q}, w_data_q, w_strb_q);
	wire [31:0] pc_m       = merge({20'h00000, pc_q}, w_data_q, w_strb_q);
	wire [31:0] ptr_m      = merge({25'h0000000, mem_ptr_q}, w_data_q, w_strb_q);
	wire [31:0] int_m      = merge({31'h00000000, pend_q}, w_data_q, w_strb_q);
	wire [31:0] mdata_m    = merge({24'h000000, mem[mem_ptr_q]}, w_data_q, w_strb_q);

	wire [31:0] status_word = {25'h0000000, sp_q, 1'b0, cycles_q, busy};
	wire [7:0]  rd_addr     = araddr;
	wire        rd_hit      = (rd_addr == instr_exec_pkg::OFF_INSTR)
		| (rd_addr == instr_exec_pkg::OFF_STATUS) | (rd_addr == instr_exec_pkg::OFF_ACC)
		| (rd_addr == instr_exec_pkg::OFF_PC) | (rd_addr == instr_exec_pkg::OFF_FLAGS)
		| (rd_addr == instr_exec_pkg::OFF_INT) | (rd_addr == instr_exec_pkg::OFF_MEM_PTR)
		| (rd_addr == instr_exec_pkg::OFF_MEM_DATA);
	wire [31:0] rd_word =
		(rd_addr == instr_exec_pkg::OFF_INSTR)    ? instr_word_q :
		(rd_addr == instr_exec_pkg::OFF_STATUS)   ? status_word :
		(rd_addr == instr_exec_pkg::OFF_ACC)      ? {24'h000000, acc_q} :
		(rd_addr == instr_exec_pkg::OFF_PC)       ? {20'h00000, pc_q} :
		(rd_addr == instr_exec_pkg::OFF_FLAGS)    ? flags_word :
		(rd_addr == instr_exec_pkg::OFF_INT)      ? {31'h00000000, pend_q} :
		(rd_addr == instr_exec_pkg::OFF_MEM_PTR)  ? {25'h0000000, mem_ptr_q} :
		(rd_addr == instr_exec_pkg::OFF_MEM_DATA) ? {24'h000000, mem[mem_ptr_q]} :
		32'h00000000;

	assign awready = !aw_full_q;
	assign wready  = !w_full_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;
	assign arready = !rvalid_q;
	assign rvalid  = rvalid_q;
	assign rdata   = rdata_q;
	assign rresp   = rresp_q;

	// Operand datapath
	wire [instr_exec_pkg::MEM_AW-1:0] m_addr = opd_q[instr_exec_pkg::MEM_AW-1:0];
	wire [DW-1:0] m_val   = mem[m_addr];
	wire [PW-1:0] pc_inc  = pc_q + 12'h001;
	wire [PW-1:0] pc_skip = pc_q + 12'h002;
	wire [PW-1:0] stack_top = stack[sp_q - 3'h1];
	wire [DW-1:0] or_mem  = acc_q | m_val;
	wire [DW-1:0] or_imm  = acc_q | opd_q;
	wire [DW-1:0] rot_l   = {m_val[6:0], m_val[7]};
	wire [DW-1:0] rot_r   = {m_val[0], m_val[7:1]};
	wire [DW-1:0] rot_lc  = {m_val[6:0], c_q};
	wire [DW-1:0] rot_rc  = {c_q, m_val[7:1]};
	// Borrow is the inverted carry, so adding the inverted byte plus carry gives acc-m-~c
	wire [DW:0]   sub_full = {1'b0, acc_q} + {1'b0, ~m_val} + {8'h00, c_q};
	wire [4:0]    sub_low  = {1'b0, acc_q[3:0]} + {1'b0, ~m_val[3:0]} + {4'h0, c_q};
	wire [DW-1:0] sub_res  = sub_full[DW-1:0];
	wire          sub_ov   = (acc_q[7] ^ m_val[7]) & (acc_q[7] ^ sub_res[7]);
	wire [DW-1:0] dec_res  = m_val - 8'h01;

	always_comb begin
		acc_d     = acc_q;
		pc_d      = pc_inc;
		c_d       = c_q;
		ac_d      = ac_q;
		z_d       = z_q;
		ov_d      = ov_q;
		emi_d     = emi_q;
		pend_clr  = 1'b0;
		mem_we    = 1'b0;
		mem_wd    = m_val;
		push      = 1'b0;
		pop       = 1'b0;
		push_val  = pc_inc;
		two_cycle = 1'b0;
		case (op_q)
			instr_exec_pkg::OP_NO_OPERATION: begin
				pc_d = pc_inc;
			end
			instr_exec_pkg::OP_JUMP_UNCONDITIONAL: begin
				pc_d      = addr_q;
				two_cycle = 1'b1;
			end
			instr_exec_pkg::OP_MOVE_MEM_TO_ACC: begin
				acc_d = m_val;
			end
			instr_exec_pkg::OP_MOVE_IMM_TO_ACC: begin
				acc_d = opd_q;
			end
			instr_exec_pkg::OP_MOVE_ACC_TO_MEM: begin
				mem_we = 1'b1;
				mem_wd = acc_q;
			end
			instr_exec_pkg::OP_OR_MEM: begin
				acc_d = or_mem;
				z_d   = (or_mem == 8'h00);
			end
			instr_exec_pkg::OP_OR_IMM: begin
				acc_d = or_imm;
				z_d   = (or_imm == 8'h00);
			end
			instr_exec_pkg::OP_OR_TO_MEMORY: begin
				mem_we = 1'b1;
				mem_wd = or_mem;
				z_d    = (or_mem == 8'h00);
			end
			instr_exec_pkg::OP_SUBROUTINE_RETURN: begin
				pop  = 1'b1;
				pc_d = stack_top;
			end
			instr_exec_pkg::OP_RETURN_WITH_VALUE: begin
				pop   = 1'b1;
				pc_d  = stack_top;
				acc_d = opd_q;
			end
			instr_exec_pkg::OP_INTERRUPT_RETURN: begin
				pop   = 1'b1;
				pc_d  = stack_top;
				emi_d = 1'b1;
				if (pend_q) begin
					// Enter the handler at once, keeping the restored address stacked
					push     = 1'b1;
					push_val = stack_top;
					pc_d     = instr_exec_pkg::INT_VECTOR;
					emi_d    = 1'b0;
					pend_clr = 1'b1;
				end
			end
			instr_exec_pkg::OP_ROTATE_LEFT: begin
				mem_we = 1'b1;
				mem_wd = rot_l;
			end
			instr_exec_pkg::OP_ROTATE_LEFT_TO_ACC: begin
				acc_d = rot_l;
			end
			instr_exec_pkg::OP_ROTATE_LEFT_CARRY: begin
				mem_we = 1'b1;
				mem_wd = rot_lc;
				c_d    = m_val[7];
			end
			instr_exec_pkg::OP_ROTATE_LEFT_CARRY_TO_ACC: begin
				acc_d = rot_lc;
				c_d   = m_val[7];
			end
			instr_exec_pkg::OP_ROTATE_RIGHT: begin
				mem_we = 1'b1;
				mem_wd = rot_r;
			end
			instr_exec_pkg::OP_ROTATE_RIGHT_TO_ACC: begin
				acc_d = rot_r;
			end
			instr_exec_pkg::OP_ROTATE_RIGHT_CARRY: begin
				mem_we = 1'b1;
				mem_wd = rot_rc;
				c_d    = m_val[0];
			end
			instr_exec_pkg::OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
				acc_d = rot_rc;
				c_d   = m_val[0];
			end
			instr_exec_pkg::OP_SUBTRACT_WITH_BORROW: begin
				acc_d = sub_res;
				c_d   = sub_full[DW];
				ac_d  = sub_low[4];
				z_d   = (sub_res == 8'h00);
				ov_d  = sub_ov;
			end
			instr_exec_pkg::OP_SUBTRACT_WITH_BORROW_TO_MEMORY: begin
				mem_we = 1'b1;
				mem_wd = sub_res;
				c_d    = sub_full[DW];
				ac_d   = sub_low[4];
				z_d    = (sub_res == 8'h00);
				ov_d   = sub_ov;
			end
			instr_exec_pkg::OP_DECREMENT_SKIP_IF_ZERO: begin
				mem_we = 1'b1;
				mem_wd = dec_res;
				if (dec_res == 8'h00) begin
					pc_d      = pc_skip;
					two_cycle = 1'b1;
				end
			end
			instr_exec_pkg::OP_SUBROUTINE_CALL: begin
				push      = 1'b1;
				push_val  = pc_inc;
				pc_d      = addr_q;
				two_cycle = 1'b1;
			end
			default: begin
				pc_d = pc_inc;
			end
		endcase
	end

	wire exec = (state_q == instr_exec_pkg::ST_EXEC);
	wire [instr_exec_pkg::STACK_AW-1:0] sp_next = sp_q + {2'h0, push} - {2'h0, pop};
	wire [instr_exec_pkg::STACK_AW-1:0] push_idx = pop ? (sp_q - 3'h1) : sp_q;

	// Bus channels
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= instr_exec_pkg::RESP_OKAY;
			rvalid_q  <= 1'b0;
			rresp_q   <= instr_exec_pkg::RESP_OKAY;
			rdata_q   <= 32'h00000000;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h00000000;
			w_strb_q  <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= awaddr;
			end else if (do_write) begin
				aw_full_q <= 1'b0;
			end
			if (wvalid && wready) begin
				w_full_q <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end else if (do_write) begin
				w_full_q <= 1'b0;
			end
			if (do_write) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_hit ? instr_exec_pkg::RESP_OKAY : instr_exec_pkg::RESP_SLVERR;
			end else if (bready) begin
				bvalid_q <= 1'b0;
			end
			if (do_read) begin
				rvalid_q <= 1'b1;
				rdata_q  <= rd_word;
				rresp_q  <= rd_hit ? instr_exec_pkg::RESP_OKAY : instr_exec_pkg::RESP_SLVERR;
			end else if (rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// Sequencer: one cycle per instruction, plus a dummy cycle where needed
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state_q      <= instr_exec_pkg::ST_IDLE;
			op_q         <= instr_exec_pkg::OP_NO_OPERATION;
			opd_q        <= 8'h00;
			addr_q       <= 12'h000;
			instr_word_q <= 32'h00000000;
			cycles_q     <= 2'h0;
		end else begin
			case (state_q)
				instr_exec_pkg::ST_IDLE: begin
					if (start) begin
						instr_word_q <= instr_m;
						op_q   <= instr_exec_pkg::opcode_t'(instr_m[INSTR_OP_MSB:0]);
						opd_q  <= instr_m[instr_exec_pkg::INSTR_OPD_LSB +: 8];
						addr_q <= instr_m[instr_exec_pkg::INSTR_ADDR_LSB +: 12];
						state_q <= instr_exec_pkg::ST_EXEC;
					end
				end
				instr_exec_pkg::ST_EXEC: begin
					state_q  <= two_cycle ? instr_exec_pkg::ST_DUMMY : instr_exec_pkg::ST_IDLE;
					cycles_q <= two_cycle ? instr_exec_pkg::CYCLES_TWO
						: instr_exec_pkg::CYCLES_ONE;
				end
				instr_exec_pkg::ST_DUMMY: begin
					state_q <= instr_exec_pkg::ST_IDLE;
				end
				default: begin
					state_q <= instr_exec_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Architectural registers
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			acc_q     <= instr_exec_pkg::ACC_RESET;
			pc_q      <= instr_exec_pkg::PC_RESET;
			c_q       <= 1'b0;
			ac_q      <= 1'b0;
			z_q       <= 1'b0;
			ov_q      <= 1'b0;
			emi_q     <= 1'b0;
			pend_q    <= 1'b0;
			sp_q      <= 3'h0;
			mem_ptr_q <= 7'h00;
		end else if (exec) begin
			acc_q <= acc_d;
			pc_q  <= pc_d;
			c_q   <= c_d;
			ac_q  <= ac_d;
			z_q   <= z_d;
			ov_q  <= ov_d;
			emi_q <= emi_d;
			sp_q  <= sp_next;
			if (pend_clr) begin
				pend_q <= 1'b0;
			end
		end else if (sw_ok) begin
			if (wr_acc) begin
				acc_q <= acc_m[DW-1:0];
			end
			if (wr_pc) begin
				pc_q <= pc_m[PW-1:0];
			end
			if (wr_flags) begin
				c_q   <= flags_m[instr_exec_pkg::FLAG_C];
				ac_q  <= flags_m[instr_exec_pkg::FLAG_AC];
				z_q   <= flags_m[instr_exec_pkg::FLAG_Z];
				ov_q  <= flags_m[instr_exec_pkg::FLAG_OV];
				emi_q <= flags_m[instr_exec_pkg::FLAG_EMI];
			end
			if (wr_int) begin
				pend_q <= int_m[0];
			end
			if (wr_ptr) begin
				mem_ptr_q <= ptr_m[instr_exec_pkg::MEM_AW-1:0];
			end
		end
	end

	// Data memory and return stack keep no reset, like the real array
	always_ff @(posedge clock) begin
		if (exec && mem_we) begin
			mem[m_addr] <= mem_wd;
		end else if (sw_ok && wr_mdata) begin
			mem[mem_ptr_q] <= mdata_m[DW-1:0];
		end
		if (exec && push) begin
			stack[push_idx] <= push_val;
		end
	end

endmodule : instr_exec

// File: instr_exec_chk.sv
// Bus handshake checker for the instruction execution block
`timescale 1ns/10ps
module instr_exec_chk (
	input wire logic        clock,
	input wire logic        rst_b,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        rvalid,
	input wire logic        rready
);
	default clocking dcb @(posedge clock); endclocking
	default disable iff (!rst_b);

	a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped or changed before accept");
	a_rresp_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read response dropped or changed before accept");
	a_arready_tracks: assert property (arready == !rvalid)
		else $error("read address ready disagrees with pending response");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read not answered one cycle after address");
	a_write_answer: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
		else $error("write response not raised on the second edge");
	a_bvalid_clears: assert property (bvalid && bready |=> !bvalid)
		else $error("write response not released after accept");
	a_aw_held: assert property (awvalid && awready |=> !awready)
		else $error("second write address accepted too early");
	a_w_held: assert property (wvalid && wready |=> !wready)
		else $error("second write data accepted too early");
	a_bresp_code: assert property (bvalid |-> bresp inside {2'h0, 2'h2})
		else $error("write response code out of set");
endmodule : instr_exec_chk

bind instr_exec instr_exec_chk instr_exec_chk_i (.clock, .rst_b, .awvalid, .awready, .wvalid,
	.wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

// File: tb_instr_exec.sv
// Self-checking bench for the instruction execution block
`timescale 1ns/10ps
module tb_instr_exec;
	logic        clock   = 1'b0;
	logic        rst_b   = 1'b0;
	logic [7:0]  awaddr  = 8'h00;
	logic        awvalid = 1'b0;
	logic [31:0] wdata   = 32'h0;
	logic [3:0]  wstrb   = 4'hF;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic [7:0]  araddr  = 8'h00;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	int          miscompares = 0;
	int          tests_run   = 0;

	instr_exec instr_exec_i (.clock, .rst_b, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready);

	always #50 clock = ~clock;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Ready is sampled mid-cycle so the handshake edge never races the bench
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		@(posedge clock);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(negedge clock);
			ta = awready;
			tw = wready;
			tb = bvalid;
			r  = bresp;
			@(posedge clock);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (!tb);
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tv;
		@(posedge clock);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(negedge clock);
			ta = arready;
			tv = rvalid;
			d  = rdata;
			r  = rresp;
			@(posedge clock);
			if (ta) arvalid <= 1'b0;
		end while (!tv);
		rready <= 1'b0;
	endtask : rd

	task automatic ck(input logic [7:0] a, input logic [11:0] e);
		logic [31:0] s;
		logic [1:0]  r;
		rd(a, s, r);
		check(s, {20'h0, e});
	endtask : ck

	task automatic wreg(input logic [7:0] a, input logic [11:0] d);
		logic [1:0] r;
		wr(a, {20'h0, d}, r);
	endtask : wreg

	task automatic set_flg(input logic [7:0] d);
		wreg(instr_exec_pkg::OFF_FLAGS, {4'h0, d});
	endtask : set_flg

	task automatic ck_flg(input logic [11:0] e);
		ck(instr_exec_pkg::OFF_FLAGS, e);
	endtask : ck_flg

	task automatic ck_acc(input logic [11:0] e);
		ck(instr_exec_pkg::OFF_ACC, e);
	endtask : ck_acc

	task automatic ck_pc(input logic [11:0] e);
		ck(instr_exec_pkg::OFF_PC, e);
	endtask : ck_pc

	task automatic set_mem(input logic [7:0] p, input logic [7:0] v);
		wreg(instr_exec_pkg::OFF_MEM_PTR, {4'h0, p});
		wreg(instr_exec_pkg::OFF_MEM_DATA, {4'h0, v});
	endtask : set_mem

	task automatic ck_mem(input logic [7:0] p, input logic [7:0] v);
		wreg(instr_exec_pkg::OFF_MEM_PTR, {4'h0, p});
		ck(instr_exec_pkg::OFF_MEM_DATA, {4'h0, v});
	endtask : ck_mem

	// Polls busy so the bench never assumes an execution latency
	task automatic run(input logic [4:0] op, input logic [7:0] opd, input logic [11:0] t,
		input logic [1:0] cyc);
		logic [31:0] s;
		logic [1:0]  r;
		wr(instr_exec_pkg::OFF_INSTR, {4'h0, t, opd, 3'h0, op}, r);
		do begin
			rd(instr_exec_pkg::OFF_STATUS, s, r);
		end while (s[0] !== 1'b0);
		check({30'h0, s[2:1]}, {30'h0, cyc});
	endtask : run

	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test

	initial begin
		#(5000 * 100);
		miscompares++;
		finish_test();
	end

	initial begin
		logic [1:0] r;
		logic [8:0] f;
		logic [4:0] h;
		logic [7:0] a, m;
		logic       c, b;
		logic [31:0] s;
		static logic [7:0] v = 8'h96;
		static logic [7:0] sa [4] = '{8'h50, 8'h30, 8'h10, 8'h80};
		static logic [7:0] sm [4] = '{8'h30, 8'h50, 8'h0F, 8'h01};
		repeat (6) @(posedge clock);
		rst_b <= 1'b1;
		ck_acc(12'h000);
		ck_pc(12'h000);
		ck_flg(12'h000);
		wr(8'h20, 32'h0, r);
		check(32'(r), 32'(instr_exec_pkg::RESP_SLVERR));
		rd(8'h20, s, r);
		check(32'(r), 32'(instr_exec_pkg::RESP_SLVERR));
		check(s, 32'h00000000);
		set_flg(8'h0F);
		run(instr_exec_pkg::OP_MOVE_IMM_TO_ACC, 8'h5A, 12'h000, 2'h1);
		ck_acc(12'h05A);
		ck_flg(12'h00F);
		run(instr_exec_pkg::OP_MOVE_ACC_TO_MEM, 8'h10, 12'h000, 2'h1);
		ck_mem(8'h10, 8'h5A);
		set_mem(8'h11, 8'hC3);
		run(instr_exec_pkg::OP_MOVE_MEM_TO_ACC, 8'h11, 12'h000, 2'h1);
		ck_acc(12'h0C3);
		run(instr_exec_pkg::OP_NO_OPERATION, 8'h00, 12'h000, 2'h1);
		ck_acc(12'h0C3);
		ck_flg(12'h00F);
		ck_pc(12'h004);
		wreg(instr_exec_pkg::OFF_ACC, 12'h000);
		set_flg(8'h0B);
		run(instr_exec_pkg::OP_OR_IMM, 8'h00, 12'h000, 2'h1);
		ck_flg(12'h00F);
		set_mem(8'h12, 8'h81);
		run(instr_exec_pkg::OP_OR_MEM, 8'h12, 12'h000, 2'h1);
		ck_acc(12'h081);
		ck_flg(12'h00B);
		set_mem(8'h13, 8'h42);
		run(instr_exec_pkg::OP_OR_TO_MEMORY, 8'h13, 12'h000, 2'h1);
		ck_mem(8'h13, 8'hC3);
		ck_acc(12'h081);
		for (int k = 0; k < 8; k++) begin
			c = k[0] ^ k[2];
			wreg(instr_exec_pkg::OFF_ACC, 12'h000);
			set_flg({4'h0, 3'b101, c});
			set_mem(8'h20, v);
			run(5'(instr_exec_pkg::OP_ROTATE_LEFT + k), 8'h20, 12'h000, 2'h1);
			f = k[2] ? {v[0], k[1] ? c : v[0], v[7:1]} : {v[7], v[6:0], k[1] ? c : v[7]};
			ck_acc(12'(k[0] ? f[7:0] : 8'h00));
			ck_mem(8'h20, k[0] ? v : f[7:0]);
			ck_flg(12'({3'b101, k[1] ? f[8] : c}));
		end
		for (int j = 0; j < 8; j++) begin
			a = sa[j / 2];
			m = sm[j / 2];
			b = j[1] & ~j[2];
			wreg(instr_exec_pkg::OFF_ACC, 12'(a));
			set_flg({7'h00, !b});
			set_mem(8'h30, m);
			run(j[0] ? instr_exec_pkg::OP_SUBTRACT_WITH_BORROW_TO_MEMORY
				: instr_exec_pkg::OP_SUBTRACT_WITH_BORROW, 8'h30, 12'h000, 2'h1);
			f = {1'b0, a} - {1'b0, m} - 9'(b);
			h = {1'b0, a[3:0]} - {1'b0, m[3:0]} - 5'(b);
			ck_acc(12'(j[0] ? a : f[7:0]));
			ck_mem(8'h30, j[0] ? f[7:0] : m);
			ck_flg(12'({a[7] != m[7] && f[7] != a[7], f[7:0] == 8'h00, !h[4], !f[8]}));
		end
		set_flg(8'h0F);
		run(instr_exec_pkg::OP_JUMP_UNCONDITIONAL, 8'h00, 12'hABC, 2'h2);
		ck_pc(12'hABC);
		ck_flg(12'h00F);
		run(instr_exec_pkg::OP_SUBROUTINE_CALL, 8'h00, 12'h123, 2'h2);
		ck_pc(12'h123);
		run(instr_exec_pkg::OP_SUBROUTINE_RETURN, 8'h00, 12'h000, 2'h1);
		ck_pc(12'hABD);
		ck_flg(12'h00F);
		run(instr_exec_pkg::OP_SUBROUTINE_CALL, 8'h00, 12'h200, 2'h2);
		run(instr_exec_pkg::OP_RETURN_WITH_VALUE, 8'h77, 12'h000, 2'h1);
		ck_pc(12'hABE);
		ck_acc(12'h077);
		ck_flg(12'h00F);
		set_flg(8'h00);
		run(instr_exec_pkg::OP_SUBROUTINE_CALL, 8'h00, 12'h310, 2'h2);
		wreg(instr_exec_pkg::OFF_INT, 12'h001);
		run(instr_exec_pkg::OP_INTERRUPT_RETURN, 8'h00, 12'h000, 2'h1);
		ck_pc(instr_exec_pkg::INT_VECTOR);
		ck(instr_exec_pkg::OFF_INT, 12'h000);
		run(instr_exec_pkg::OP_INTERRUPT_RETURN, 8'h00, 12'h000, 2'h1);
		ck_pc(12'hABF);
		ck_flg(12'h010);
		set_mem(8'h40, 8'h02);
		run(instr_exec_pkg::OP_DECREMENT_SKIP_IF_ZERO, 8'h40, 12'h000, 2'h1);
		ck_mem(8'h40, 8'h01);
		ck_pc(12'hAC0);
		run(instr_exec_pkg::OP_DECREMENT_SKIP_IF_ZERO, 8'h40, 12'h000, 2'h2);
		ck_mem(8'h40, 8'h00);
		ck_pc(12'hAC2);
		ck_flg(12'h010);
		// Unassigned codes fall through to the no-operation path
		run(5'h1F, 8'h40, 12'h000, 2'h1);
		ck_pc(12'hAC3);
		ck_mem(8'h40, 8'h00);
		finish_test();
	end
endmodule : tb_instr_exec
